// ---- fca_consts.svh ----
// fca_consts.svh: offsets, reset values and limits of the credit block
// assumes inclusion by bare name from the design files
`ifndef FCA_CONSTS_SVH
`define FCA_CONSTS_SVH

`define FCA_ADDR_W        8
`define FCA_OFS_CTRL      8'h00
`define FCA_OFS_INIT_HDR  8'h04
`define FCA_OFS_INIT_DATA 8'h08
`define FCA_OFS_THR_HDR   8'h0C
`define FCA_OFS_THR_PD    8'h10
`define FCA_OFS_THR_NPD   8'h14
`define FCA_OFS_THR_CPLD  8'h18
`define FCA_OFS_TMR_LIM   8'h1C
`define FCA_OFS_STATUS    8'h20
`define FCA_OFS_UPD_CNT   8'h24

`define FCA_RST_INF       6'h3F
`define FCA_RST_INI_H     7'h00
`define FCA_RST_INI_D     8'h00
`define FCA_RST_THR_H     7'h08
`define FCA_RST_THR_D     11'h0FF
`define FCA_RST_TMR_LIM   12'hFFF

`define FCA_MIN_INI_H     12'h001
`define FCA_MIN_INI_D     12'h008
`define FCA_MIN_THR       12'h001
`define FCA_MIN_TMR_LIM   12'hEA6

`define FCA_HDR_FLD_W     8
`define FCA_DATA_FLD_W    12
`define FCA_CNT_W         12
`define FCA_NKIND         3

`endif

// ---- fca_credit_adv.sv ----
// fca_credit_adv.sv: receive credit advertising and UpdateFC scheduling
// assumes an APB master, a DLLP transmitter that acks each request and
// a link state input from the data link layer init machine
//
// Notes on behaviour
// RQ1 - during init, InitFC1 then InitFC2 carry the configured credit amounts
// RQ2 - each of six credit kinds has its own infinite credit option
// RQ3 - user picks infinite only if it sinks every TLP of that kind at once
// RQ4 - finite header kinds advertise an initial count of 1 to 127
// RQ5 - finite data kinds advertise an initial count of 8 to 255
// RQ6 - user sizes finite initial credits to its real receive buffering
// RQ7 - after init, UpdateFC goes out on credit thresholds or timer expiry
// RQ8 - posted header credits reaching threshold (1-127, default 8) send UpdateFC-P
// RQ9 - posted data credits reaching threshold (1-2047, default 255) send UpdateFC-P
// RQ10 - non-posted header or data thresholds send UpdateFC-NP
// RQ11 - completion header or data thresholds send completion UpdateFC
// RQ12 - timer limit 3750 to 4095 cycles, default 4095, bounds update spacing
// RQ13 - timer expiry sends updates for all three types regardless of releases
// RQ14 - infinite kinds send zero fields; counters and timer restart after update; the timer here restarts only on expiry or when the link leaves active
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fca_consts.svh"

module fca_credit_adv
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [`FCA_ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire fca_pkg::fca_dl_t           dl_state,
	input  wire logic                       rel_ph,
	input  wire logic                       rel_nph,
	input  wire logic                       rel_cplh,
	input  wire logic [7:0]                 rel_pd,
	input  wire logic [7:0]                 rel_npd,
	input  wire logic [7:0]                 rel_cpld,
	output logic                            upd_valid,
	input  wire logic                       upd_ack,
	output fca_pkg::fca_dllp_t              upd_kind,
	output fca_pkg::fca_type_t              upd_type,
	output logic [`FCA_HDR_FLD_W-1:0]       upd_hdr,
	output logic [`FCA_DATA_FLD_W-1:0]      upd_data
);
	import fca_pkg::*;

	localparam int NK = `FCA_NKIND;

	function automatic logic [11:0] sat_add(input logic [11:0] a,
		input logic [11:0] b);
		logic [12:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[12] ? 12'hFFF : s[11:0];
	endfunction

	function automatic logic [11:0] at_least(input logic [11:0] v,
		input logic [11:0] lo);
		return (v < lo) ? lo : v;
	endfunction

	logic [5:0]  inf_reg;
	logic [6:0]  ini_h_reg [NK];
	logic [7:0]  ini_d_reg [NK];
	logic [6:0]  thr_h_reg [NK];
	logic [10:0] thr_d_reg [NK];
	logic [11:0] tlim_reg;
	logic [31:0] prdata_reg;
	logic [15:0] upd_cnt_reg;

	logic [11:0] hcnt_reg [NK];
	logic [11:0] dcnt_reg [NK];
	logic [11:0] hcnt_next [NK];
	logic [11:0] dcnt_next [NK];
	logic [7:0]  htot_reg [NK];
	logic [11:0] dtot_reg [NK];
	logic [11:0] hinc [NK];
	logic [11:0] dinc [NK];
	logic [7:0]  hfld [NK];
	logic [11:0] dfld [NK];
	logic [NK-1:0] hit;
	logic [NK-1:0] pend_reg;
	logic [11:0] tmr_reg;
	logic        tmr_exp;

	logic        upd_valid_reg;
	fca_dllp_t   upd_kind_reg;
	fca_type_t   upd_type_reg;
	logic [7:0]  upd_hdr_reg;
	logic [11:0] upd_data_reg;
	logic [1:0]  rr_reg;

	logic        can_load;
	logic        load;
	logic [1:0]  sel;
	logic        in_init;
	logic        active;
	logic        hit_addr;
	logic        wr_en;
	logic [31:0] rdata;

	assign in_init = (dl_state == FCA_DL_FC1) || (dl_state == FCA_DL_FC2);
	assign active = (dl_state == FCA_DL_ACTIVE);

	// bus slave: zero wait states, unmapped offsets answer with pslverr
	always_comb
	begin
		hit_addr = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			`FCA_OFS_CTRL:      rdata = {26'h0, inf_reg};
			`FCA_OFS_INIT_HDR:  rdata = {9'h0, ini_h_reg[2], 1'b0,
				ini_h_reg[1], 1'b0, ini_h_reg[0]};
			`FCA_OFS_INIT_DATA: rdata = {8'h0, ini_d_reg[2], ini_d_reg[1],
				ini_d_reg[0]};
			`FCA_OFS_THR_HDR:   rdata = {9'h0, thr_h_reg[2], 1'b0,
				thr_h_reg[1], 1'b0, thr_h_reg[0]};
			`FCA_OFS_THR_PD:    rdata = {21'h0, thr_d_reg[0]};
			`FCA_OFS_THR_NPD:   rdata = {21'h0, thr_d_reg[1]};
			`FCA_OFS_THR_CPLD:  rdata = {21'h0, thr_d_reg[2]};
			`FCA_OFS_TMR_LIM:   rdata = {20'h0, tlim_reg};
			`FCA_OFS_STATUS:    rdata = {4'h0, tmr_reg, 10'h0, dl_state,
				upd_valid_reg, pend_reg};
			`FCA_OFS_UPD_CNT:   rdata = {16'h0, upd_cnt_reg};
			default:            hit_addr = 1'b0;
		endcase
	end

	assign wr_en = psel && penable && pwrite && hit_addr;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_addr;
	assign prdata = prdata_reg;

	// read data captured in the setup phase so it comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_reg <= rdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			inf_reg <= `FCA_RST_INF;
			tlim_reg <= `FCA_RST_TMR_LIM;
			for (int k = 0; k < NK; k++)
			begin
				ini_h_reg[k] <= `FCA_RST_INI_H;
				ini_d_reg[k] <= `FCA_RST_INI_D;
				thr_h_reg[k] <= `FCA_RST_THR_H;
				thr_d_reg[k] <= `FCA_RST_THR_D;
			end
		end
		else if (wr_en)
		begin
			unique case (paddr)
				`FCA_OFS_CTRL:      inf_reg <= pwdata[5:0]; // RQ2
				`FCA_OFS_INIT_HDR:
					for (int k = 0; k < NK; k++)
						ini_h_reg[k] <= pwdata[8*k +: 7];
				`FCA_OFS_INIT_DATA:
					for (int k = 0; k < NK; k++)
						ini_d_reg[k] <= pwdata[8*k +: 8];
				`FCA_OFS_THR_HDR:
					for (int k = 0; k < NK; k++)
						thr_h_reg[k] <= pwdata[8*k +: 7];
				`FCA_OFS_THR_PD:    thr_d_reg[0] <= pwdata[10:0];
				`FCA_OFS_THR_NPD:   thr_d_reg[1] <= pwdata[10:0];
				`FCA_OFS_THR_CPLD:  thr_d_reg[2] <= pwdata[10:0];
				`FCA_OFS_TMR_LIM:   tlim_reg <= pwdata[11:0];
				default:            ;
			endcase
		end
	end

	// advertised fields: initial value plus credits released so far
	always_comb
	begin
		hinc[0] = {11'h0, rel_ph};
		hinc[1] = {11'h0, rel_nph};
		hinc[2] = {11'h0, rel_cplh};
		dinc[0] = {4'h0, rel_pd};
		dinc[1] = {4'h0, rel_npd};
		dinc[2] = {4'h0, rel_cpld};
		for (int k = 0; k < NK; k++)
		begin
			hfld[k] = inf_reg[k] ? 8'h00 : // RQ14
				8'(at_least({5'h0, ini_h_reg[k]}, `FCA_MIN_INI_H)) +
				htot_reg[k]; // RQ4
			dfld[k] = inf_reg[3+k] ? 12'h000 : // RQ14
				at_least({4'h0, ini_d_reg[k]}, `FCA_MIN_INI_D) +
				dtot_reg[k]; // RQ5
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int k = 0; k < NK; k++)
			begin
				htot_reg[k] <= 8'h00;
				dtot_reg[k] <= 12'h000;
			end
		else if (!active)
			for (int k = 0; k < NK; k++)
			begin
				htot_reg[k] <= 8'h00;
				dtot_reg[k] <= 12'h000;
			end
		else
			for (int k = 0; k < NK; k++)
			begin
				htot_reg[k] <= htot_reg[k] + hinc[k][7:0];
				dtot_reg[k] <= dtot_reg[k] + dinc[k];
			end
	end

	// credits released in the cycle of a load count toward the next one
	always_comb
	begin
		for (int k = 0; k < NK; k++)
		begin
			if (load && sel == 2'(k))
			begin
				hcnt_next[k] = hinc[k]; // RQ14
				dcnt_next[k] = dinc[k]; // RQ14
			end
			else
			begin
				hcnt_next[k] = sat_add(hcnt_reg[k], hinc[k]);
				dcnt_next[k] = sat_add(dcnt_reg[k], dinc[k]);
			end
			hit[k] = active && // RQ7
				((hcnt_next[k] >= at_least({5'h0, thr_h_reg[k]},
				`FCA_MIN_THR)) || // RQ8 RQ10 RQ11
				(dcnt_next[k] >= at_least({1'h0, thr_d_reg[k]},
				`FCA_MIN_THR))); // RQ9 RQ10 RQ11
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int k = 0; k < NK; k++)
			begin
				hcnt_reg[k] <= 12'h000;
				dcnt_reg[k] <= 12'h000;
			end
		else if (!active)
			for (int k = 0; k < NK; k++)
			begin
				hcnt_reg[k] <= 12'h000;
				dcnt_reg[k] <= 12'h000;
			end
		else
			for (int k = 0; k < NK; k++)
			begin
				hcnt_reg[k] <= hcnt_next[k];
				dcnt_reg[k] <= dcnt_next[k];
			end
	end

	// worst-case spacing timer, limit clamped into its legal range
	assign tmr_exp = active && (tmr_reg >=
		at_least(tlim_reg, `FCA_MIN_TMR_LIM) - 12'h001); // RQ12

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tmr_reg <= 12'h000;
		else if (!active || tmr_exp)
			tmr_reg <= 12'h000; // RQ14
		else
			tmr_reg <= tmr_reg + 12'h001; // RQ12
	end

	// a new trigger in the load cycle keeps the type pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_reg <= '0;
		else
			for (int k = 0; k < NK; k++)
				pend_reg[k] <= hit[k] || tmr_exp || // RQ13
					(pend_reg[k] && !(load && sel == 2'(k)));
	end

	assign can_load = !upd_valid_reg || upd_ack;

	always_comb
	begin
		load = 1'b0;
		sel = rr_reg;
		if (can_load && in_init)
			load = 1'b1; // RQ1
		else if (can_load && active && pend_reg != '0)
		begin
			load = 1'b1; // RQ7
			sel = pend_reg[0] ? 2'd0 : (pend_reg[1] ? 2'd1 : 2'd2);
		end
	end

	// init DLLPs cycle P, NP, CPL for as long as the init state lasts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rr_reg <= 2'd0;
		else if (!in_init)
			rr_reg <= 2'd0;
		else if (load)
			rr_reg <= (rr_reg == 2'd2) ? 2'd0 : rr_reg + 2'd1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			upd_valid_reg <= 1'b0;
			upd_kind_reg <= FCA_K_INIT1;
			upd_type_reg <= FCA_T_P;
			upd_hdr_reg <= 8'h00;
			upd_data_reg <= 12'h000;
		end
		else if (dl_state == FCA_DL_IDLE)
			upd_valid_reg <= 1'b0;
		else if (load)
		begin
			upd_valid_reg <= 1'b1;
			upd_kind_reg <= (dl_state == FCA_DL_FC1) ? FCA_K_INIT1 :
				(dl_state == FCA_DL_FC2) ? FCA_K_INIT2 : FCA_K_UPD; // RQ1
			upd_type_reg <= fca_type_t'(sel);
			upd_hdr_reg <= hfld[sel]; // RQ1
			upd_data_reg <= dfld[sel]; // RQ1
		end
		else if (upd_ack)
			upd_valid_reg <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			upd_cnt_reg <= 16'h0000;
		else if (load && active)
			upd_cnt_reg <= upd_cnt_reg + 16'h0001;
	end

	assign upd_valid = upd_valid_reg;
	assign upd_kind = upd_kind_reg;
	assign upd_type = upd_type_reg;
	assign upd_hdr = upd_hdr_reg;
	assign upd_data = upd_data_reg;
endmodule

// ---- fca_credit_adv_props.sv ----
// fca_credit_adv_props.sv: port checker for the credit block
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module fca_credit_adv_props
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [7:0]         paddr,
	input wire logic               pslverr,
	input wire fca_pkg::fca_dl_t   dl_state,
	input wire logic               upd_valid,
	input wire logic               upd_ack,
	input wire fca_pkg::fca_dllp_t upd_kind,
	input wire fca_pkg::fca_type_t upd_type,
	input wire logic [7:0]         upd_hdr,
	input wire logic [11:0]        upd_data
);
	import fca_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	hold_a: assert property (upd_valid && !upd_ack && dl_state !=
		FCA_DL_IDLE |=> $stable({upd_valid, upd_kind, upd_type})
		&& $stable({upd_hdr, upd_data})) else $error("request moved");
	idle_a: assert property (dl_state == FCA_DL_IDLE |=> !upd_valid)
		else $error("request survives idle link");
	init1_a: assert property (upd_valid && (!$past(upd_valid) ||
		$past(upd_ack)) && $past(dl_state) == FCA_DL_FC1 |->
		upd_kind == FCA_K_INIT1) else $error("wrong first init kind");
	init2_a: assert property (upd_valid && (!$past(upd_valid) ||
		$past(upd_ack)) && $past(dl_state) == FCA_DL_FC2 |->
		upd_kind == FCA_K_INIT2) else $error("wrong second init kind");
	upd_a: assert property (upd_valid && (!$past(upd_valid) ||
		$past(upd_ack)) && $past(dl_state) == FCA_DL_ACTIVE |->
		upd_kind == FCA_K_UPD) else $error("wrong update kind");
	rr_a: assert property (upd_valid && upd_ack && upd_type == FCA_T_CPL
		&& dl_state == FCA_DL_FC2 |=> upd_valid && upd_type == FCA_T_P)
		else $error("init types out of turn");
	load_a: assert property (!upd_valid && dl_state == FCA_DL_FC1
		|=> upd_valid) else $error("init request not raised");
	err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
		else $error("unmapped access not refused");
	cover property (upd_valid && upd_ack && upd_kind == FCA_K_UPD);
	cover property (upd_valid && upd_ack && upd_kind == FCA_K_INIT2);
	cover property (psel && penable && pslverr);
endmodule

bind fca_credit_adv fca_credit_adv_props u_props (.pclk, .presetn, .psel,
	.penable, .paddr, .pslverr, .dl_state, .upd_valid, .upd_ack,
	.upd_kind, .upd_type, .upd_hdr, .upd_data);

// ---- fca_pkg.sv ----
// fca_pkg.sv: types shared by the credit advertise / update block
// assumes nothing beyond a SystemVerilog compiler
package fca_pkg;
	typedef enum logic [1:0] {FCA_DL_IDLE, FCA_DL_FC1, FCA_DL_FC2,
		FCA_DL_ACTIVE} fca_dl_t;
	typedef enum logic [1:0] {FCA_K_INIT1, FCA_K_INIT2, FCA_K_UPD}
		fca_dllp_t;
	typedef enum logic [1:0] {FCA_T_P, FCA_T_NP, FCA_T_CPL} fca_type_t;
endpackage

// ---- fca_tx_model.sv ----
// fca_tx_model.sv: DLLP transmitter standing at the far side
// assumes requests hold until acked; wait_cyc sets the stall
`timescale 1ns/1ps
module fca_tx_model
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       upd_valid,
	input  wire logic [1:0] wait_cyc,
	output logic            upd_ack
);
	logic [1:0] cnt_reg;

	// one ack per request, never on an idle line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 2'h0;
			upd_ack <= 1'b0;
		end
		else if (upd_ack || !upd_valid)
		begin
			cnt_reg <= 2'h0;
			upd_ack <= 1'b0;
		end
		else if (cnt_reg == wait_cyc)
			upd_ack <= 1'b1;
		else
			cnt_reg <= cnt_reg + 2'h1;
	end
endmodule

// ---- test_fca_credit_adv.sv ----
// test_fca_credit_adv.sv: self-checking bench for the credit block
// assumes the transmitter model and the checker are compiled first
`timescale 1ns/1ps
module test_fca_credit_adv;
	import fca_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rel_pd, rel_npd, rel_cpld, upd_hdr;
	logic [31:0] pwdata, prdata, rd;
	logic        rel_ph, rel_nph, rel_cplh, upd_valid, upd_ack, err;
	fca_dl_t     dl_state;
	fca_dllp_t   upd_kind;
	fca_type_t   upd_type;
	logic [11:0] upd_data;
	logic [1:0]  wait_cyc;
	logic [23:0] q[$];
	logic [7:0]  eh[3] = '{8'h00, 8'h01, 8'h7F};
	logic [11:0] ed[3] = '{12'h008, 12'h0FF, 12'h000};
	logic [7:0]  ra[5] = '{8'h00, 8'h0C, 8'h10, 8'h1C, 8'h04};
	logic [31:0] rv[5] = '{32'h3F, 32'h80808, 32'hFF, 32'hFFF, 32'h0};
	int          failures, compares, cyc;

	fca_credit_adv dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .dl_state, .rel_ph, .rel_nph,
		.rel_cplh, .rel_pd, .rel_npd, .rel_cpld, .upd_valid, .upd_ack,
		.upd_kind, .upd_type, .upd_hdr, .upd_data);
	fca_tx_model u_tx (.pclk, .presetn, .upd_valid, .wait_cyc, .upd_ack);

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		if (upd_valid === 1'b1 && upd_ack === 1'b1)
			q.push_back({upd_kind, upd_type, upd_hdr, upd_data});
		cyc++;
		if (cyc > 20000)
		begin
			failures++;
			summarize();
		end
	end

	task automatic summarize();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(logic [31:0] g, logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic exp_dllp(fca_dllp_t k, fca_type_t t);
		int n;
		n = 0;
		while (q.size() == 0 && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
		chk((q.size() > 0) ? q.pop_front() : 32'hFFFFFFFF,
			{8'h00, k, t, eh[t], ed[t]});
	endtask

	task automatic pulse(logic [2:0] h, logic [7:0] pd, logic [7:0] npd);
		@(posedge pclk);
		{rel_ph, rel_nph, rel_cplh} <= h;
		rel_pd <= pd;
		rel_npd <= npd;
		@(posedge pclk);
		{rel_ph, rel_nph, rel_cplh} <= 3'h0;
		rel_pd <= 8'h00;
		rel_npd <= 8'h00;
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, rel_ph, rel_nph, rel_cplh} = 7'h0;
		{paddr, pwdata, rel_pd, rel_npd, rel_cpld} = 64'h0;
		dl_state = FCA_DL_IDLE;
		wait_cyc = 2'h2;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 8'h00, 32'h21);
		apb(1'b1, 8'h04, 32'h7F0105);
		apb(1'b1, 8'h08, 32'h14FF08);
		dl_state <= FCA_DL_FC1;
		exp_dllp(FCA_K_INIT1, FCA_T_P);
		exp_dllp(FCA_K_INIT1, FCA_T_NP);
		exp_dllp(FCA_K_INIT1, FCA_T_CPL);
		dl_state <= FCA_DL_FC2;
		exp_dllp(FCA_K_INIT1, FCA_T_P);
		exp_dllp(FCA_K_INIT2, FCA_T_NP);
		exp_dllp(FCA_K_INIT2, FCA_T_CPL);
		wait_cyc <= 2'h0;
		dl_state <= FCA_DL_ACTIVE;
		repeat (10) @(posedge pclk);
		q.delete();
		apb(1'b1, 8'h0C, 32'h10802);
		apb(1'b1, 8'h10, 32'h4);
		apb(1'b1, 8'h14, 32'h3);
		pulse(3'h4, 8'h0, 8'h0);
		repeat (5) @(posedge pclk);
		chk(q.size(), 32'h0);
		pulse(3'h4, 8'h0, 8'h0);
		exp_dllp(FCA_K_UPD, FCA_T_P);
		ed[FCA_T_P] = 12'h00C;
		pulse(3'h0, 8'h4, 8'h0);
		exp_dllp(FCA_K_UPD, FCA_T_P);
		ed[FCA_T_NP] = 12'h102;
		pulse(3'h0, 8'h0, 8'h3);
		exp_dllp(FCA_K_UPD, FCA_T_NP);
		eh[FCA_T_CPL] = 8'h80;
		pulse(3'h1, 8'h0, 8'h0);
		exp_dllp(FCA_K_UPD, FCA_T_CPL);
		apb(1'b0, 8'h24, 32'h0);
		chk(rd, 32'h4);
		apb(1'b1, 8'h1C, 32'h0);
		dl_state <= FCA_DL_IDLE;
		@(posedge pclk);
		dl_state <= FCA_DL_ACTIVE;
		eh = '{8'h00, 8'h01, 8'h7F};
		ed = '{12'h008, 12'h0FF, 12'h000};
		repeat (3700) @(posedge pclk);
		chk(q.size(), 32'h0);
		exp_dllp(FCA_K_UPD, FCA_T_P);
		exp_dllp(FCA_K_UPD, FCA_T_NP);
		exp_dllp(FCA_K_UPD, FCA_T_CPL);
		summarize();
	end
endmodule
